// file: design/port_phy_control_register.sv
`include "port_phy_cfg.svh"
module port_phy_control_register
  import port_phy_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [`ADDR_W-1:0]   addr,
  input  wire logic [`DATA_W-1:0]   wdata,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  output logic      [`DATA_W-1:0]   rdata,
  input  wire logic [3:0]           indicator_in,
  input  wire logic                 an_done,
  input  wire logic                 an_ok,
  input  wire logic [1:0]           an_mode,
  output logic                      port_indicator_3,
  output logic                      port_indicator_2,
  output logic                      port_indicator_1,
  output logic                      port_indicator_0,
  output logic                      tx_disable,
  output logic                      an_restart,
  output logic                      fef_disable,
  output logic                      power_down,
  output logic                      auto_x_disable,
  output logic                      mdix_force,
  output logic                      an_enable,
  output logic [1:0]                link_mode,
  output logic [4:0]                advert
);
  logic [`DATA_W-1:0] ctrl_ff;
  logic [3:0]         ind_s1_ff;
  logic [3:0]         ind_s2_ff;
  logic               done_s1_ff;
  logic               done_s2_ff;
  logic               ok_s1_ff;
  logic               ok_s2_ff;
  logic [1:0]         mode_s1_ff;
  logic [1:0]         mode_s2_ff;
  link_mode_type      sel_mode;

  // Address decode is shared by the write and read selects.
  function automatic logic reg_hit(input logic [`ADDR_W-1:0] a,
                                   input logic [`ADDR_W-1:0] off);
    return a == off;
  endfunction

  // Restart is a self-clearing strobe, never stored, so it always reads 0.
  wire logic hit_ctrl  = reg_hit(addr, `OFF_PORT_PHY_CTRL);
  wire logic hit_basic = reg_hit(addr, `OFF_BASIC_CTRL);
  wire logic hit_adv   = reg_hit(addr, `OFF_ADVERT);
  wire logic wr_ctrl   = wr_stb && hit_ctrl;
  wire logic wr_basic  = wr_stb && hit_basic;
  wire logic wr_adv    = wr_stb && hit_adv;

  // Both alias views map onto one storage word, so neither can go stale.
  wire logic [`DATA_W-1:0] basic_view = {2'h0, ctrl_ff[`BIT_SPEED], ctrl_ff[`BIT_AN_EN],
    ctrl_ff[`BIT_PWR_DOWN], 1'b0, 1'b0, ctrl_ff[`BIT_DUPLEX], 3'h0,
    ctrl_ff[`BIT_FORCE_X], ctrl_ff[`BIT_AUTO_X_DIS], ctrl_ff[`BIT_FEF_DIS],
    ctrl_ff[`BIT_TX_DIS], ctrl_ff[`BIT_IND_OFF]};
  wire logic [`DATA_W-1:0] adv_view = {5'h0, ctrl_ff[`BIT_ADV_PAUSE], 1'b0,
    ctrl_ff[`BIT_ADV_100F], ctrl_ff[`BIT_ADV_100H], ctrl_ff[`BIT_ADV_10F],
    ctrl_ff[`BIT_ADV_10H], 5'h0};

  wire logic [`DATA_W-1:0] from_basic = {wdata[`BC_IND_OFF],
    wdata[`BC_TX_DIS], 1'b0, wdata[`BC_FEF_DIS], wdata[`BC_PWR_DOWN],
    wdata[`BC_AUTO_X_DIS], wdata[`BC_FORCE_X], 1'b0, wdata[`BC_AN_EN],
    wdata[`BC_SPEED], wdata[`BC_DUPLEX], ctrl_ff[4:0]};
  wire logic [`DATA_W-1:0] from_adv = {ctrl_ff[15:5], wdata[`AD_PAUSE],
    wdata[`AD_100F], wdata[`AD_100H], wdata[`AD_10F], wdata[`AD_10H]};
  // Reserved bit 8 and the restart strobe bit are never stored.
  wire logic [`DATA_W-1:0] store_mask = ~((16'h0001 << `BIT_RSVD) |
                                          (16'h0001 << `BIT_AN_RESTART));

  wire logic [`DATA_W-1:0] nxt_ctrl =
    wr_ctrl  ? (wdata & store_mask) :
    wr_basic ? from_basic :
    wr_adv   ? from_adv : ctrl_ff;
  wire logic nxt_restart = (wr_ctrl && wdata[`BIT_AN_RESTART]) ||
                           (wr_basic && wdata[`BC_AN_RESTART]);
  wire logic [`DATA_W-1:0] nxt_rdata =
    !rd_stb   ? 16'h0000 :
    hit_ctrl  ? ctrl_ff :
    hit_basic ? basic_view :
    hit_adv   ? adv_view : 16'h0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= `CTRL_RESET_VAL;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Indicator and negotiation levels come from outside this clock, so they pass two flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_s1_ff  <= 4'h0;
      ind_s2_ff  <= 4'h0;
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      ok_s1_ff   <= 1'b0;
      ok_s2_ff   <= 1'b0;
      mode_s1_ff <= 2'h0;
      mode_s2_ff <= 2'h0;
    end else begin
      ind_s1_ff  <= indicator_in;
      ind_s2_ff  <= ind_s1_ff;
      done_s1_ff <= an_done;
      done_s2_ff <= done_s1_ff;
      ok_s1_ff   <= an_ok;
      ok_s2_ff   <= ok_s1_ff;
      mode_s1_ff <= an_mode;
      mode_s2_ff <= mode_s1_ff;
    end
  end

  port_phy_mode_sel u_mode_sel (
    .an_en        (ctrl_ff[`BIT_AN_EN]),
    .an_done      (done_s2_ff),
    .an_ok        (ok_s2_ff),
    .an_mode      (link_mode_type'(mode_s2_ff)),
    .force_speed  (ctrl_ff[`BIT_SPEED]),
    .force_duplex (ctrl_ff[`BIT_DUPLEX]),
    .mode         (sel_mode)
  );

  // Outputs are registered, so control effects lag the write by one cycle, link_mode by two.
  wire logic [3:0] nxt_ind = nxt_ctrl[`BIT_IND_OFF] ? 4'hf : ind_s2_ff;
  wire logic nxt_mdix = nxt_ctrl[`BIT_AUTO_X_DIS] && nxt_ctrl[`BIT_FORCE_X];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata            <= 16'h0000;
      port_indicator_3 <= 1'b0;
      port_indicator_2 <= 1'b0;
      port_indicator_1 <= 1'b0;
      port_indicator_0 <= 1'b0;
      tx_disable       <= 1'b0;
      an_restart       <= 1'b0;
      fef_disable      <= 1'b0;
      power_down       <= 1'b0;
      auto_x_disable   <= 1'b0;
      mdix_force       <= 1'b0;
      an_enable        <= 1'b1;
      link_mode        <= 2'h0;
      advert           <= 5'h1f;
    end else begin
      rdata            <= nxt_rdata;
      port_indicator_3 <= nxt_ind[3];
      port_indicator_2 <= nxt_ind[2];
      port_indicator_1 <= nxt_ind[1];
      port_indicator_0 <= nxt_ind[0];
      tx_disable       <= nxt_ctrl[`BIT_TX_DIS];
      an_restart       <= nxt_restart;
      fef_disable      <= nxt_ctrl[`BIT_FEF_DIS];
      power_down       <= nxt_ctrl[`BIT_PWR_DOWN];
      auto_x_disable   <= nxt_ctrl[`BIT_AUTO_X_DIS];
      mdix_force       <= nxt_mdix;
      an_enable        <= nxt_ctrl[`BIT_AN_EN];
      link_mode        <= sel_mode;
      advert           <= nxt_ctrl[4:0];
    end
  end

  // Indicators load from the same next word as the register, so a set off bit
  // and forced-high pins are seen in the same cycle.
  ind_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_ff[`BIT_IND_OFF] |-> {port_indicator_3, port_indicator_2,
                               port_indicator_1, port_indicator_0} == 4'hf)
    else $error("indicators not forced high");

  ind_pass_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl_ff[`BIT_IND_OFF] |-> {port_indicator_3, port_indicator_2,
                                port_indicator_1, port_indicator_0} == $past(ind_s2_ff))
    else $error("indicators not passed through");

  tx_dis_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl |=> tx_disable == $past(wdata[`BIT_TX_DIS]))
    else $error("transmit disable did not follow write");

  // Back-to-back restart writes legally stretch the pulse, so only a lone one is timed.
  restart_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ctrl && wdata[`BIT_AN_RESTART]) ##1 !nxt_restart |-> an_restart ##1 !an_restart)
    else $error("restart strobe wrong");

  restart_alias_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_basic && wdata[`BC_AN_RESTART]) |=> an_restart)
    else $error("restart through basic view lost");

  restart_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(wr_ctrl && wdata[`BIT_AN_RESTART]) && !(wr_basic && wdata[`BC_AN_RESTART])
      |=> !an_restart)
    else $error("restart pulse without a write");

  fef_dis_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl |=> fef_disable == $past(wdata[`BIT_FEF_DIS]))
    else $error("far-end-fault disable wrong");

  pwr_dn_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl |=> power_down == $past(wdata[`BIT_PWR_DOWN]))
    else $error("power down did not follow write");

  auto_x_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl |=> auto_x_disable == $past(wdata[`BIT_AUTO_X_DIS]))
    else $error("auto crossover disable wrong");

  mdix_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
    mdix_force |-> auto_x_disable)
    else $error("crossover forced with auto selection on");

  mdix_on_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ctrl && wdata[`BIT_AUTO_X_DIS] && wdata[`BIT_FORCE_X]) |=> mdix_force)
    else $error("crossover not forced");

  mdix_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ctrl && !wdata[`BIT_FORCE_X]) |=> !mdix_force)
    else $error("crossover forced without request");

  an_en_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl |=> an_enable == $past(wdata[`BIT_AN_EN]))
    else $error("negotiation enable did not follow write");

  forced_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl_ff[`BIT_AN_EN] |=> link_mode == $past({ctrl_ff[`BIT_SPEED],
                                                 ctrl_ff[`BIT_DUPLEX]}))
    else $error("forced speed or duplex not applied");

  an_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_ff[`BIT_AN_EN] && !(done_s2_ff && !ok_s2_ff)) |=> link_mode == $past(mode_s2_ff))
    else $error("negotiated mode not applied");

  an_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_ff[`BIT_AN_EN] && done_s2_ff && !ok_s2_ff)
      |=> link_mode[0] == $past(ctrl_ff[`BIT_DUPLEX]))
    else $error("failed negotiation duplex fallback wrong");

  advert_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_adv |=> advert == {$past(wdata[`AD_PAUSE]), $past(wdata[`AD_100F]),
                          $past(wdata[`AD_100H]), $past(wdata[`AD_10F]),
                          $past(wdata[`AD_10H])})
    else $error("advertised bits wrong");

  adv_ctrl_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_ctrl |=> advert == $past(wdata[`BIT_ADV_PAUSE:`BIT_ADV_10H]))
    else $error("advertised bits did not follow write");

  adv_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_adv |=> $stable(tx_disable) && $stable(an_enable))
    else $error("advertisement write touched control bits");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl_ff[`BIT_RSVD] && !ctrl_ff[`BIT_AN_RESTART])
    else $error("reserved bit stored");

  alias_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_basic |=> power_down == $past(wdata[`BC_PWR_DOWN]))
    else $error("alias write lost");

  basic_an_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_basic |=> an_enable == $past(wdata[`BC_AN_EN]))
    else $error("basic view negotiation enable lost");

  basic_tx_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_basic |=> tx_disable == $past(wdata[`BC_TX_DIS]))
    else $error("basic view transmit disable lost");

  basic_fef_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_basic |=> fef_disable == $past(wdata[`BC_FEF_DIS]))
    else $error("basic view far-end-fault disable lost");

  unmapped_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_stb && !hit_ctrl && !hit_basic && !hit_adv) |=> $stable(ctrl_ff))
    else $error("unmapped write changed the register");

  rd_ctrl_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_stb && hit_ctrl) |=> rdata == $past(ctrl_ff))
    else $error("control read data wrong");

  rd_basic_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_stb && hit_basic) |=> rdata[`BC_AN_EN] == $past(ctrl_ff[`BIT_AN_EN]))
    else $error("basic view read data wrong");

  rd_adv_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_stb && hit_adv) |=> rdata[`AD_PAUSE] == $past(ctrl_ff[`BIT_ADV_PAUSE]))
    else $error("advertisement view read data wrong");

  rd_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !rd_stb |=> rdata == 16'h0000)
    else $error("read data without a read");
endmodule

// file: design/port_phy_cfg.svh
`ifndef PORT_PHY_CFG_SVH
`define PORT_PHY_CFG_SVH
`define ADDR_W              8
`define DATA_W              16
`define OFF_PORT_PHY_CTRL   8'h02
`define OFF_BASIC_CTRL      8'h10
`define OFF_ADVERT          8'h12
`define CTRL_RESET_VAL      16'h009f
`define BIT_IND_OFF         15
`define BIT_TX_DIS          14
`define BIT_AN_RESTART      13
`define BIT_FEF_DIS         12
`define BIT_PWR_DOWN        11
`define BIT_AUTO_X_DIS      10
`define BIT_FORCE_X         9
`define BIT_RSVD            8
`define BIT_AN_EN           7
`define BIT_SPEED           6
`define BIT_DUPLEX          5
`define BIT_ADV_PAUSE       4
`define BIT_ADV_100F        3
`define BIT_ADV_100H        2
`define BIT_ADV_10F         1
`define BIT_ADV_10H         0
`define BC_IND_OFF          0
`define BC_TX_DIS           1
`define BC_FEF_DIS          2
`define BC_AUTO_X_DIS       3
`define BC_FORCE_X          4
`define BC_DUPLEX           8
`define BC_AN_RESTART       9
`define BC_PWR_DOWN         11
`define BC_AN_EN            12
`define BC_SPEED            13
`define AD_10H              5
`define AD_10F              6
`define AD_100H             7
`define AD_100F             8
`define AD_PAUSE            10
`endif

// file: design/port_phy_pkg.sv
package port_phy_pkg;
  typedef enum logic [1:0] {
    SPD_10_HALF,
    SPD_10_FULL,
    SPD_100_HALF,
    SPD_100_FULL
  } link_mode_type;
endpackage

// file: design/port_phy_mode_sel.sv
`include "port_phy_cfg.svh"
module port_phy_mode_sel
  import port_phy_pkg::*;
(
  input  wire logic          an_en,
  input  wire logic          an_done,
  input  wire logic          an_ok,
  input  wire link_mode_type an_mode,
  input  wire logic          force_speed,
  input  wire logic          force_duplex,
  output link_mode_type      mode
);
  // A failed negotiation keeps its resolved speed but falls back to the forced duplex.
  wire logic forced_fall = !an_en;
  wire logic an_failed   = an_en && an_done && !an_ok;
  wire logic sel_speed   = forced_fall ? force_speed : an_mode[1];
  wire logic sel_duplex  = (forced_fall || an_failed) ? force_duplex : an_mode[0];
  assign mode = link_mode_type'({sel_speed, sel_duplex});
endmodule

// file: verif/tb_port_phy_control_register.sv
`include "port_phy_cfg.svh"
module tb_port_phy_control_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [3:0]  indicator_in = 4'h5;
  logic        an_done = 1'b1;
  logic        an_ok = 1'b1;
  logic [1:0]  an_mode = 2'h2;
  logic [15:0] rdata;
  logic [3:0]  ind;
  logic        tx_disable, an_restart, fef_disable, power_down;
  logic        auto_x_disable, mdix_force, an_enable;
  logic [1:0]  link_mode;
  logic [4:0]  advert;
  int          err_count = 0;
  int          checks_done = 0;

  always #20 clk = ~clk;

  port_phy_control_register port_phy_control_register_i (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .indicator_in(indicator_in), .an_done(an_done),
    .an_ok(an_ok), .an_mode(an_mode), .port_indicator_3(ind[3]),
    .port_indicator_2(ind[2]), .port_indicator_1(ind[1]), .port_indicator_0(ind[0]),
    .tx_disable(tx_disable), .an_restart(an_restart), .fef_disable(fef_disable),
    .power_down(power_down), .auto_x_disable(auto_x_disable), .mdix_force(mdix_force),
    .an_enable(an_enable), .link_mode(link_mode), .advert(advert));

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask

  // Outputs load with the control word but link_mode lags it one cycle, so settle first.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    close_out;
  end

  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    settle(5);
    chk("advert", advert, 16'h1f);
    chk("an_enable", an_enable, 1'b1);
    chk("tx_disable", tx_disable, 1'b0);
    chk("ind", ind, 4'h5);
    rdchk(`OFF_PORT_PHY_CTRL, 16'h009f);
    $display("test reset done");
    wr(`OFF_PORT_PHY_CTRL, 16'hffff);
    chk("an_restart", an_restart, 1'b1);
    settle(1);
    chk("an_restart", an_restart, 1'b0);
    chk("ind", ind, 4'hf);
    chk("tx_disable", tx_disable, 1'b1);
    chk("fef_disable", fef_disable, 1'b1);
    chk("power_down", power_down, 1'b1);
    chk("auto_x_disable", auto_x_disable, 1'b1);
    chk("mdix_force", mdix_force, 1'b1);
    rdchk(`OFF_PORT_PHY_CTRL, 16'hdeff);
    settle(0);
    @(posedge clk) #1 chk("rdata", rdata, 16'h0000);
    wr(`OFF_PORT_PHY_CTRL, 16'h0200);
    settle(1);
    chk("mdix_force", mdix_force, 1'b0);
    chk("auto_x_disable", auto_x_disable, 1'b0);
    chk("ind", ind, 4'h5);
    chk("power_down", power_down, 1'b0);
    chk("fef_disable", fef_disable, 1'b0);
    chk("tx_disable", tx_disable, 1'b0);
    $display("test control bits done");
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_PORT_PHY_CTRL, 16'(i) << 5);
      settle(1);
      chk("link_mode", link_mode, 16'(i));
      chk("an_enable", an_enable, 1'b0);
    end
    wr(`OFF_PORT_PHY_CTRL, 16'h0080);
    settle(1);
    chk("link_mode", link_mode, 16'h2);
    @(posedge clk);
    an_ok <= 1'b0;
    wr(`OFF_PORT_PHY_CTRL, 16'h00a0);
    settle(5);
    chk("dup", link_mode[0], 1'b1);
    wr(`OFF_PORT_PHY_CTRL, 16'h0080);
    settle(1);
    chk("dup", link_mode[0], 1'b0);
    $display("test link mode done");
    wr(`OFF_ADVERT, 16'h0000);
    settle(1);
    chk("advert", advert, 16'h00);
    for (int k = 0; k < 5; k++) begin
      wr(`OFF_PORT_PHY_CTRL, 16'h0080 | (16'h1 << k));
      settle(1);
      chk("advert", advert, 16'h1 << k);
    end
    wr(`OFF_BASIC_CTRL, 16'h1201);
    chk("an_restart", an_restart, 1'b1);
    rdchk(`OFF_PORT_PHY_CTRL, 16'h8090);
    rdchk(`OFF_BASIC_CTRL, 16'h1001);
    rdchk(`OFF_ADVERT, 16'h0400);
    wr(8'h40, 16'hffff);
    rdchk(8'h40, 16'h0000);
    wr(`OFF_PORT_PHY_CTRL, 16'h0190);
    rdchk(`OFF_PORT_PHY_CTRL, 16'h0090);
    $display("test alias done");
    @(posedge clk);
    arst_n <= 1'b0;
    settle(2);
    chk("advert", advert, 16'h1f);
    chk("an_enable", an_enable, 1'b1);
    @(posedge clk);
    arst_n <= 1'b1;
    settle(3);
    rdchk(`OFF_PORT_PHY_CTRL, 16'h009f);
    $display("test second reset done");
    close_out;
  end
endmodule
